//--- include/psw_pkg.sv
package psw_pkg;
	// ---------------------------------------------------------------
	// register address and fields
	// ---------------------------------------------------------------
	localparam logic [7:0] PSW_ADDR        = 8'hD0;
	localparam logic [7:0] PSW_RESET       = 8'h00;
	localparam int         CARRY_BIT       = 7;
	localparam int         HALF_CARRY_BIT  = 6;
	localparam int         USER_ZERO_BIT   = 5;
	localparam int         BANK_HIGH_BIT   = 4;
	localparam int         BANK_LOW_BIT    = 3;
	localparam int         EXCESS_BIT      = 2;
	localparam int         USER_ONE_BIT    = 1;
	localparam int         PARITY_BIT      = 0;
	localparam logic [4:0] BANK_STRIDE     = 5'h08;
	localparam logic [8:0] MUL_BYTE_MAX    = 9'h0FF;

	// ---------------------------------------------------------------
	// arithmetic operation codes
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ADD,
		OP_ADDC,
		OP_SUBB,
		OP_MUL,
		OP_DIV,
		OP_OTHER
	} alu_op_e;
endpackage

//--- hdl/parity_calc.sv
`timescale 1ns/1ps
module parity_calc #(
	parameter int WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_odd
);
	assign o_odd = ^i_data;
endmodule // parity_calc

//--- hdl/program_status_flags.sv
`timescale 1ns/1ps
module program_status_flags (
	input  wire logic           i_mclk,
	input  wire logic           i_resetn,
	input  wire logic           i_op_valid,
	input  wire psw_pkg::alu_op_e i_op,
	input  wire logic [7:0]     i_opa,
	input  wire logic [7:0]     i_opb,
	input  wire logic [7:0]     i_acc,
	input  wire logic           i_sfr_wr,
	input  wire logic [7:0]     i_sfr_addr,
	input  wire logic [7:0]     i_sfr_wdata,
	input  wire logic           i_bit_wr,
	input  wire logic [2:0]     i_bit_sel,
	input  wire logic           i_bit_val,
	output logic      [7:0]     o_psw,
	output logic      [4:0]     o_bank_base
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] psw;
		logic [4:0] base;
	} state_s;

	state_s     st_ff;
	state_s     nxt_st;
	logic       par_odd;
	logic       cin;
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [8:0] dif9;
	logic [4:0] dif5;
	logic       add_ov;
	logic       sub_ov;
	logic [15:0] prod;

	// limitation: parity lags the accumulator by one clock, since every output is registered
	parity_calc #(.WIDTH(8)) u_par (
		.i_data (i_acc),
		.o_odd  (par_odd)
	);

	// ---------------------------------------------------------------
	// arithmetic flag sources
	// ---------------------------------------------------------------
	always_comb begin
		cin    = (i_op == psw_pkg::OP_ADD) ? 1'b0 : st_ff.psw[psw_pkg::CARRY_BIT];
		sum9   = {1'b0, i_opa} + {1'b0, i_opb} + {8'h00, cin};
		sum5   = {1'b0, i_opa[3:0]} + {1'b0, i_opb[3:0]} + {4'h0, cin};
		dif9   = {1'b0, i_opa} - {1'b0, i_opb} - {8'h00, cin};
		dif5   = {1'b0, i_opa[3:0]} - {1'b0, i_opb[3:0]} - {4'h0, cin};
		add_ov = (i_opa[7] == i_opb[7]) && (sum9[7] != i_opa[7]);
		sub_ov = (i_opa[7] != i_opb[7]) && (dif9[7] != i_opa[7]);
		prod   = {8'h00, i_opa} * {8'h00, i_opb};
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		if (i_sfr_wr && i_sfr_addr == psw_pkg::PSW_ADDR) begin
			nxt_st.psw[7:1] = i_sfr_wdata[7:1];
		end else if (i_bit_wr && i_bit_sel != 3'h0) begin
			nxt_st.psw[i_bit_sel] = i_bit_val;
		end else if (i_op_valid) begin
			// excess is a plain compare, a miss clears it
			case (i_op)
				psw_pkg::OP_ADD, psw_pkg::OP_ADDC: begin
					nxt_st.psw[psw_pkg::CARRY_BIT]      = sum9[8];
					nxt_st.psw[psw_pkg::HALF_CARRY_BIT] = sum5[4];
					nxt_st.psw[psw_pkg::EXCESS_BIT]     = add_ov;
				end
				psw_pkg::OP_SUBB: begin
					nxt_st.psw[psw_pkg::CARRY_BIT]      = dif9[8];
					nxt_st.psw[psw_pkg::HALF_CARRY_BIT] = dif5[4];
					nxt_st.psw[psw_pkg::EXCESS_BIT]     = sub_ov;
				end
				psw_pkg::OP_MUL: begin
					nxt_st.psw[psw_pkg::CARRY_BIT]  = 1'b0;
					nxt_st.psw[psw_pkg::HALF_CARRY_BIT] = 1'b0;
					nxt_st.psw[psw_pkg::EXCESS_BIT] = (prod > {7'h00, psw_pkg::MUL_BYTE_MAX});
				end
				psw_pkg::OP_DIV: begin
					nxt_st.psw[psw_pkg::CARRY_BIT]  = 1'b0;
					nxt_st.psw[psw_pkg::HALF_CARRY_BIT] = 1'b0;
					nxt_st.psw[psw_pkg::EXCESS_BIT] = (i_opb == 8'h00);
				end
				psw_pkg::OP_OTHER: begin
					// limitation: other arithmetic clears carries, overflow is kept
					nxt_st.psw[psw_pkg::CARRY_BIT]      = 1'b0;
					nxt_st.psw[psw_pkg::HALF_CARRY_BIT] = 1'b0;
				end
				default: begin
					nxt_st.psw = st_ff.psw;
				end
			endcase
		end
		nxt_st.psw[psw_pkg::PARITY_BIT] = par_odd;
		nxt_st.base = 5'({nxt_st.psw[psw_pkg::BANK_HIGH_BIT], nxt_st.psw[psw_pkg::BANK_LOW_BIT]}) *
			psw_pkg::BANK_STRIDE;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			st_ff <= '{psw: psw_pkg::PSW_RESET, base: 5'h00};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_psw       = st_ff.psw;
	assign o_bank_base = st_ff.base;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	// an operation counts only when no software write can claim the cycle
	sequence s_add_op;
		i_op_valid && !i_sfr_wr && !i_bit_wr && (i_op == psw_pkg::OP_ADD);
	endsequence

	sequence s_addc_op;
		i_op_valid && !i_sfr_wr && !i_bit_wr && (i_op == psw_pkg::OP_ADDC);
	endsequence

	sequence s_sub_op;
		i_op_valid && !i_sfr_wr && !i_bit_wr && (i_op == psw_pkg::OP_SUBB);
	endsequence

	sequence s_mul_op;
		i_op_valid && !i_sfr_wr && !i_bit_wr && (i_op == psw_pkg::OP_MUL);
	endsequence

	sequence s_div_op;
		i_op_valid && !i_sfr_wr && !i_bit_wr && (i_op == psw_pkg::OP_DIV);
	endsequence

	sequence s_other_op;
		i_op_valid && !i_sfr_wr && !i_bit_wr && (i_op == psw_pkg::OP_OTHER);
	endsequence

	sequence s_user_bit;
		i_bit_wr && !i_sfr_wr && (i_bit_sel != 3'h0);
	endsequence

	sequence s_byte_wr;
		i_sfr_wr && (i_sfr_addr == psw_pkg::PSW_ADDR);
	endsequence

	// ---------------------------------------------------------------
	// checks: carry and half carry
	// ---------------------------------------------------------------
	// add carry out
	a_add_carry: assert property (s_add_op
		|=> o_psw[7] == (({1'b0, $past(i_opa)} + {1'b0, $past(i_opb)}) > 9'h0FF))
		else $error("carry wrong after add");
	a_addc_carry: assert property (s_addc_op
		|=> o_psw[7] == (({1'b0, $past(i_opa)} + {1'b0, $past(i_opb)} + {8'h00, $past(o_psw[7])}) > 9'h0FF))
		else $error("carry wrong after add with carry");
	a_add_half: assert property (s_add_op
		|=> o_psw[6] == (({1'b0, $past(i_opa[3:0])} + {1'b0, $past(i_opb[3:0])}) > 5'h0F))
		else $error("half carry wrong after add");
	a_sub_borrow: assert property (s_sub_op
		|=> o_psw[7] == ({1'b0, $past(i_opa)} < ({1'b0, $past(i_opb)} + {8'h00, $past(o_psw[7])})))
		else $error("carry wrong after subtract");
	a_sub_half: assert property (s_sub_op
		|=> o_psw[6] == ({1'b0, $past(i_opa[3:0])} < ({1'b0, $past(i_opb[3:0])} + {4'h0, $past(o_psw[7])})))
		else $error("half carry wrong after subtract");
	a_mul_clear: assert property (s_mul_op |=> !o_psw[7] && !o_psw[6])
		else $error("carries not cleared by multiply");
	a_div_clear: assert property (s_div_op |=> !o_psw[7] && !o_psw[6])
		else $error("carries not cleared by divide");
	a_other_clear: assert property (s_other_op
		|=> !o_psw[7] && !o_psw[6] && $stable(o_psw[2]))
		else $error("other arithmetic flags wrong");

	// ---------------------------------------------------------------
	// checks: software side
	// ---------------------------------------------------------------
	// hardware keeps user flags
	a_user_hold: assert property (!i_sfr_wr && !i_bit_wr |=> $stable(o_psw[5]) && $stable(o_psw[1]))
		else $error("user flag changed by hardware");
	a_user_write: assert property (s_user_bit
		|=> o_psw[$past(i_bit_sel)] == $past(i_bit_val))
		else $error("bit write lost");
	a_bank_base: assert property (o_bank_base == {o_psw[4:3], 3'h0})
		else $error("bank base mismatch");
	a_bank_write: assert property (s_byte_wr
		|=> o_bank_base == {$past(i_sfr_wdata[4:3]), 3'h0})
		else $error("bank base not taken from write");

	// ---------------------------------------------------------------
	// checks: overflow
	// ---------------------------------------------------------------
	// add sign overflow
	a_add_ovf: assert property (s_add_op ##0 (i_opa == 8'h7F && i_opb == 8'h01) |=> o_psw[2])
		else $error("add overflow not set");
	a_sub_ovf: assert property (s_sub_op ##0 (i_opa == 8'h80 && i_opb == 8'h01) |=> o_psw[2])
		else $error("subtract overflow not set");
	a_mul_ovf: assert property (s_mul_op
		|=> o_psw[2] == (({8'h00, $past(i_opa)} * {8'h00, $past(i_opb)}) > 16'h00FF))
		else $error("multiply overflow wrong");
	a_div_zero: assert property (s_div_op
		|=> o_psw[2] == ($past(i_opb) == 8'h00))
		else $error("divide by zero flag wrong");
	a_ovf_clear: assert property (s_add_op ##0 (i_opa == 8'h01 && i_opb == 8'h01) |=> !o_psw[2])
		else $error("overflow not cleared");
	a_add_noovf: assert property (s_add_op ##0 (i_opa[7] != i_opb[7]) |=> !o_psw[2])
		else $error("overflow not cleared by add");
	a_sub_noovf: assert property (s_sub_op ##0 (i_opa[7] == i_opb[7]) |=> !o_psw[2])
		else $error("overflow not cleared by subtract");

	// ---------------------------------------------------------------
	// checks: parity
	// ---------------------------------------------------------------
	// parity tracks accumulator
	a_parity_track: assert property (##1 o_psw[0] == ^$past(i_acc))
		else $error("parity stale");
	a_parity_nowr: assert property (s_byte_wr
		|=> o_psw[7:1] == $past(i_sfr_wdata[7:1]) && o_psw[0] == ^$past(i_acc))
		else $error("write handling wrong");
endmodule // program_status_flags

//--- dv/alu_core_model.sv
`timescale 1ns/1ps
module alu_core_model (
	input  wire logic        i_mclk,
	output logic             o_op_valid,
	output psw_pkg::alu_op_e o_op,
	output logic [7:0]       o_opa,
	output logic [7:0]       o_opb,
	output logic [7:0]       o_acc
);
	initial begin
		o_op_valid = 1'b0;
		o_op = psw_pkg::OP_NONE;
		o_opa = 8'h00;
		o_opb = 8'h00;
		o_acc = 8'h00;
	end
	// operands inverted once released, so stale values cannot pass for live ones
	task automatic issue(input psw_pkg::alu_op_e op, input logic [7:0] a, input logic [7:0] b);
		@(negedge i_mclk);
		o_op_valid = 1'b1;
		o_op = op;
		o_opa = a;
		o_opb = b;
		@(negedge i_mclk);
		o_op_valid = 1'b0;
		o_opa = ~a;
		o_opb = ~b;
	endtask
	task automatic set_acc(input logic [7:0] v);
		@(negedge i_mclk);
		o_acc = v;
	endtask
endmodule // alu_core_model

//--- dv/program_status_flags_tb.sv
`timescale 1ns/1ps
module program_status_flags_tb;
	logic             mclk = 1'b0;
	logic             resetn = 1'b0;
	logic             sfr_wr = 1'b0;
	logic [7:0]       sfr_addr = 8'h00;
	logic [7:0]       sfr_wdata = 8'h00;
	logic             bit_wr = 1'b0;
	logic [2:0]       bit_sel = 3'h0;
	logic             bit_val = 1'b0;
	logic             op_valid;
	psw_pkg::alu_op_e op;
	logic [7:0]       opa;
	logic [7:0]       opb;
	logic [7:0]       acc;
	logic [7:0]       psw;
	logic [4:0]       bank_base;
	int               bad_count = 0;
	int               n_tests = 0;
	always #12.5 mclk = ~mclk;
	alu_core_model u_core (.i_mclk(mclk), .o_op_valid(op_valid), .o_op(op), .o_opa(opa), .o_opb(opb), .o_acc(acc));
	program_status_flags u_dut (.i_mclk(mclk), .i_resetn(resetn), .i_op_valid(op_valid), .i_op(op), .i_opa(opa),
		.i_opb(opb), .i_acc(acc), .i_sfr_wr(sfr_wr), .i_sfr_addr(sfr_addr), .i_sfr_wdata(sfr_wdata),
		.i_bit_wr(bit_wr), .i_bit_sel(bit_sel), .i_bit_val(bit_val), .o_psw(psw), .o_bank_base(bank_base));
	// ---------------------------------------------------------------
	// access tasks
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic sfr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		@(negedge mclk);
		sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
		@(negedge mclk);
		sfr_wr = 1'b0;
		sfr_wdata = ~d;
		chk("psw", exp, psw);
	endtask
	task automatic bitw(input logic [2:0] s, input logic [7:0] exp);
		@(negedge mclk);
		bit_wr = 1'b1;
		bit_sel = s;
		bit_val = 1'b1;
		@(negedge mclk);
		bit_wr = 1'b0;
		bit_val = 1'b0;
		chk("psw", exp, psw);
	endtask
	task automatic alu(input psw_pkg::alu_op_e o, input logic [7:0] a, input logic [7:0] b, input logic [7:0] exp);
		u_core.issue(o, a, b);
		chk("psw", exp, psw);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (20) @(negedge mclk);
		resetn = 1'b1;
		@(negedge mclk);
		chk("reset", 8'h00, psw);
		sfr(8'hD0, 8'hFF, 8'hFE);
		for (int b = 0; b < 4; b++) begin
			sfr(8'hD0, 8'(b * 8), 8'(b * 8));
			chk("bank", 8'(b * 8), {3'h0, bank_base});
		end
		sfr(8'hD1, 8'h00, 8'h18);
		bitw(3'h5, 8'h38);
		bitw(3'h1, 8'h3A);
		bitw(3'h0, 8'h3A);
		u_core.set_acc(8'h07);
		@(negedge mclk);
		chk("parity", 8'h3B, psw);
		u_core.set_acc(8'h00);
		@(negedge mclk);
		alu(psw_pkg::OP_ADD, 8'h7F, 8'h01, 8'h7E);
		alu(psw_pkg::OP_ADD, 8'hFF, 8'h01, 8'hFA);
		alu(psw_pkg::OP_ADDC, 8'h00, 8'h00, 8'h3A);
		alu(psw_pkg::OP_SUBB, 8'h00, 8'h01, 8'hFA);
		alu(psw_pkg::OP_SUBB, 8'h80, 8'h01, 8'h7E);
		alu(psw_pkg::OP_MUL, 8'h0F, 8'h11, 8'h3A);
		alu(psw_pkg::OP_MUL, 8'h10, 8'h10, 8'h3E);
		alu(psw_pkg::OP_DIV, 8'h05, 8'h01, 8'h3A);
		alu(psw_pkg::OP_DIV, 8'h05, 8'h00, 8'h3E);
		alu(psw_pkg::OP_OTHER, 8'h01, 8'h01, 8'h3E);
		alu(psw_pkg::OP_ADD, 8'h01, 8'h01, 8'h3A);
		alu(psw_pkg::OP_NONE, 8'hFF, 8'hFF, 8'h3A);
		wrap_up();
	end
endmodule // program_status_flags_tb
